// file: rtl/mt_timer_top.sv
// Eight-bit modulo timer with selectable source, prescaler, overflow
// flag and interrupt request, reached over classic Wishbone.
// Assumes one bus clock; pins arrive asynchronous, mode inputs do not.
//
// Contract
// R1: Eight-bit up-counter, free-running or modulo
// R2: Four sources: bus, fixed, pin rise, pin fall
// R3: Fixed source is reference clock halved
// R4: Divide by two to power zero..eight
// R5: Counts in wait; interrupt ends wait
// R6: Halts entirely in every stop mode
// R7: Stop exit keeps state; reset restores defaults
// R8: Debug suspends counting; resets still act
// R9: External pin synchronised before edge detection
// R10: Pin frequency at most quarter bus clock
// R11: Flag bit 7 sets on wrap to zero
// R12: Flag clears by read then zero write
// R13: Counter reset or modulo write clears flag
// R14: Request while flag and enable bit 6
// R15: Software clears flag before enabling interrupt
// R16: Bit 5 write one zeroes counter, reads zero
// R17: Bit 4 freezes counter; reset sets it
// R18: Four eight-bit registers exposed
// R19: Source codes 00 bus to 11 rise
// R20: Prescale codes above 1000 divide by 256
// R21: Wrap at nonzero modulo; zero runs free
// R22: Overflow during clear keeps flag set
// R23: Reset write beats coincident overflow
//
// The address map and register access over Wishbone were chosen for this implementation.
`timescale 1ns/1ps
module mt_timer_top (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input mt_pkg::mt_wb_req_s wb_req_i,
    output mt_pkg::mt_wb_rsp_s wb_rsp_o,
    // Clock inputs from outside the bus domain
    input wire logic ext_timer_clock_pin_i,
    input wire logic internal_fixed_ref_clock_i,
    // System mode levels, bus clock domain
    input wire logic stop_mode_i,
    input wire logic debug_active_i,
    // Interrupt request
    output logic irq_o
);
    import mt_pkg::*;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic overflow_flag;
        logic ie;
        logic stp;
        logic [1:0] csel;
        logic [MT_PS_W-1:0] psel;
        logic [MT_CNT_W-1:0] cnt;
        logic [MT_CNT_W-1:0] modv;
        logic armed;
        logic fix_half;
        logic irq;
        logic ack;
        logic [31:0] rdat;
    } mt_top_s;

    mt_top_s st_reg;
    mt_top_s st_next;

    logic ext_rise;
    logic ext_fall;
    logic ref_rise;
    logic fix_tick;
    logic src_tick;
    logic run;
    logic cnt_tick;
    logic acc;
    logic wr;
    logic rd;
    logic sc_wr;
    logic clk_wr;
    logic mod_wr;
    logic trst;
    logic clr_evt;
    logic ovf;
    logic clear_req;
    logic [MT_CNT_W-1:0] wrap;
    logic [7:0] wbyte;
    logic [7:0] rbyte;

    // ------------------------------------------------------------------
    // Clock sources
    // ------------------------------------------------------------------

    // External pin, two flops before any edge logic
    mt_edge_sync u_ext_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .async_i(ext_timer_clock_pin_i),
        .rise_o(ext_rise),
        .fall_o(ext_fall)
    );

    // Reference clock sampled the same way as a pin
    mt_edge_sync u_ref_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .async_i(internal_fixed_ref_clock_i),
        .rise_o(ref_rise),
        .fall_o()
    );

    // Halved reference rises on every second reference rise
    assign fix_tick = ref_rise & ~st_reg.fix_half; // R3

    // Source mux; the bus clock gives a tick every cycle
    always_comb begin
        case (mt_src_e'(st_reg.csel)) // R2 R19
            MT_SRC_BUS: src_tick = 1'b1;
            MT_SRC_FIX: src_tick = fix_tick;
            MT_SRC_EXT_FALL: src_tick = ext_fall;
            MT_SRC_EXT_RISE: src_tick = ext_rise;
            default: src_tick = 1'b0;
        endcase
    end

    // Wait mode is not a term here, so counting goes on in wait
    assign run = ~st_reg.stp & ~stop_mode_i & ~debug_active_i; // R5 R6 R8 R17

    // Prescaler pauses with the counter so no partial count leaks
    mt_prescaler u_ps (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ps_i(st_reg.psel),
        .clr_i(clr_evt),
        .tick_i(src_tick & run),
        .tick_o(cnt_tick)
    );

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------

    // Access taken in the cycle before ack; ack then blocks a repeat
    assign acc = wb_req_i.cyc & wb_req_i.stb & ~st_reg.ack;
    assign wr = acc & wb_req_i.we & wb_req_i.sel[MT_WB_BYTE0];
    assign rd = acc & ~wb_req_i.we;
    assign wbyte = wb_req_i.dat[7:0];
    assign sc_wr = wr & (wb_req_i.adr == MT_OFF_SC);
    assign clk_wr = wr & (wb_req_i.adr == MT_OFF_CLK);
    assign mod_wr = wr & (wb_req_i.adr == MT_OFF_MOD);
    assign trst = sc_wr & wbyte[MT_SC_TRST_BIT]; // R16
    assign clr_evt = trst | mod_wr; // R13

    // Zero-write clears only after a read saw the flag set
    assign clear_req = sc_wr & ~wbyte[MT_SC_TOF_BIT] & st_reg.armed; // R12

    // Read mux; unmapped and misaligned addresses read as zero
    always_comb begin
        case (wb_req_i.adr) // R18
            MT_OFF_SC: begin
                rbyte = 8'h00;
                rbyte[MT_SC_TOF_BIT] = st_reg.overflow_flag;
                rbyte[MT_SC_IE_BIT] = st_reg.ie;
                rbyte[MT_SC_STP_BIT] = st_reg.stp; // R16
            end
            MT_OFF_CLK: begin
                rbyte = 8'h00;
                rbyte[MT_CLK_CSEL_LSB+:2] = st_reg.csel;
                rbyte[MT_CLK_PS_LSB+:MT_PS_W] = st_reg.psel;
            end
            MT_OFF_CNT: rbyte = st_reg.cnt;
            MT_OFF_MOD: rbyte = st_reg.modv;
            default: rbyte = 8'h00;
        endcase
    end

    // ------------------------------------------------------------------
    // Counter and overflow
    // ------------------------------------------------------------------

    // A zero modulo means the counter wraps only after all ones
    assign wrap = (st_reg.modv == MT_CNT_ZERO) ? MT_CNT_FULL : st_reg.modv; // R21
    assign ovf = cnt_tick & (st_reg.cnt == wrap); // R1 R21

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------

    // Next state: counter, flag, control fields and bus answer
    always_comb begin
        st_next = st_reg;
        st_next.ack = acc;
        st_next.rdat = MT_DAT_ZERO;
        if (rd) begin
            st_next.rdat[7:0] = rbyte;
        end

        if (ref_rise) begin
            st_next.fix_half = ~st_reg.fix_half; // R3
        end

        // Counter: reset writes beat any tick of the same cycle
        if (clr_evt) begin
            st_next.cnt = MT_CNT_ZERO; // R16 R23
        end else if (cnt_tick) begin
            st_next.cnt = ovf ? MT_CNT_ZERO : st_reg.cnt + MT_CNT_ONE; // R1
        end

        // Flag: reset write wins, then set wins over the zero write
        if (clr_evt) begin
            st_next.overflow_flag = 1'b0; // R13 R23
        end else if (ovf) begin
            st_next.overflow_flag = 1'b1; // R11 R22
        end else if (clear_req) begin
            st_next.overflow_flag = 1'b0; // R12
        end

        // Arming: an overflow, even one beside the read, restarts it;
        // that read returned the flag from before this overflow
        if (sc_wr || ovf || clr_evt) begin
            st_next.armed = 1'b0; // R22
        end else if (rd && wb_req_i.adr == MT_OFF_SC && st_reg.overflow_flag) begin
            st_next.armed = 1'b1; // R12
        end

        // Control fields
        if (sc_wr) begin
            st_next.ie = wbyte[MT_SC_IE_BIT];
            st_next.stp = wbyte[MT_SC_STP_BIT]; // R17
        end
        if (clk_wr) begin
            st_next.csel = wbyte[MT_CLK_CSEL_LSB+:2]; // R19
            st_next.psel = wbyte[MT_CLK_PS_LSB+:MT_PS_W]; // R20
        end
        if (mod_wr) begin
            st_next.modv = wbyte;
        end

        // Request follows flag and enable; it also ends wait
        st_next.irq = st_next.overflow_flag & st_next.ie; // R5 R14 R15

        // Only a reset restores defaults; stop exit keeps all state
        if (rst_i) begin
            st_next = '0;
            st_next.stp = MT_RST_STP; // R7 R17
            st_next.ie = MT_RST_IE; // R14
            st_next.overflow_flag = MT_RST_TOF;
            st_next.psel = MT_RST_PS;
            st_next.csel = MT_SRC_BUS;
            st_next.modv = MT_RST_MOD;
        end
    end

    always_ff @(posedge clk_i) begin
        st_reg <= st_next;
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign wb_rsp_o.ack = st_reg.ack;
    assign wb_rsp_o.dat = st_reg.rdat;
    assign irq_o = st_reg.irq;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    // One clock domain; a reset cycle disables every check
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // Counter reset and modulo writes
    chk_trst_zeroes: assert property (trst |=> // R16
        (st_reg.cnt == MT_CNT_ZERO) && !st_reg.overflow_flag)
        else $error("counter reset write did not zero count and flag");

    chk_mod_write: assert property (mod_wr |=> // R13
        st_reg.cnt == MT_CNT_ZERO && !st_reg.overflow_flag
        && st_reg.modv == $past(wbyte))
        else $error("modulo write did not reset count and flag");

    // A new source keeps the count; only a tick may move it
    chk_src_keeps: assert property (clk_wr && !cnt_tick |=> // R19
        $stable(st_reg.cnt))
        else $error("source change disturbed the count");

    // Halt conditions
    chk_stop_bit_hold: assert property (st_reg.stp && !clr_evt |=> // R17
        $stable(st_reg.cnt))
        else $error("counter moved while stop bit set");

    chk_stop_mode_halt: assert property (stop_mode_i && !wr |=> // R6
        $stable(st_reg.cnt) && $stable(st_reg.overflow_flag))
        else $error("timer changed during stop mode");

    chk_debug_hold: assert property (debug_active_i && !clr_evt |=> // R8
        $stable(st_reg.cnt))
        else $error("counter moved during debug");

    // Overflow flag and its two-step clear
    chk_wrap_sets_flag: assert property (ovf && !clr_evt |=> // R11
        st_reg.overflow_flag && st_reg.cnt == MT_CNT_ZERO)
        else $error("overflow did not set flag and wrap");

    chk_set_over_clear: assert property (ovf && clear_req // R22
        && !clr_evt |=> st_reg.overflow_flag)
        else $error("overflow lost to clearing write");

    // Any overflow restarts the clear, so a second one is not missed
    chk_ovf_disarms: assert property (ovf |=> !st_reg.armed) // R22
        else $error("overflow left the clear armed");

    chk_clear_needs_arm: assert property (st_reg.overflow_flag && !st_reg.armed // R12
        && !clr_evt |=> st_reg.overflow_flag)
        else $error("flag cleared without prior read");

    // Request, counting and wrap
    chk_irq_level: assert property (irq_o == (st_reg.overflow_flag && st_reg.ie)) // R14
        else $error("interrupt request differs from flag and enable");

    chk_bus_count: assert property (run && st_reg.csel == MT_SRC_BUS // R4 R19
        && st_reg.psel == MT_RST_PS && !clr_evt && st_reg.cnt != wrap
        |=> st_reg.cnt == $past(st_reg.cnt) + MT_CNT_ONE)
        else $error("bus clock divide by one did not step count");

    chk_free_wrap: assert property (ovf && st_reg.modv == MT_CNT_ZERO // R21
        |-> st_reg.cnt == MT_CNT_FULL)
        else $error("free-running wrap not at all ones");

    chk_fix_spacing: assert property (fix_tick |=> !fix_tick [*3]) // R3
        else $error("fixed source ticks too close");

    // Bus answer
    chk_ack_drop: assert property (wb_rsp_o.ack |=> !wb_rsp_o.ack)
        else $error("ack held longer than one cycle");

    // ------------------------------------------------------------------
    // Main scenarios reached
    // ------------------------------------------------------------------
    cov_overflow: cover property (ovf ##1 irq_o);
    cov_two_step: cover property (st_reg.armed ##[1:20] (clear_req && !ovf));
    cov_ext_count: cover property (st_reg.csel == MT_SRC_EXT_RISE && cnt_tick);
    cov_mod_run: cover property (st_reg.modv != MT_CNT_ZERO && ovf);
    cov_debug_reset: cover property (debug_active_i && clr_evt);

endmodule // mt_timer_top

// file: rtl/mt_pkg.sv
// Package for the eight-bit modulo timer: register map, field positions,
// reset values, clock source codes and the bus carrier structs.
// Assumes a classic Wishbone master with 32-bit data and byte addresses.
package mt_pkg;

    // ------------------------------------------------------------------
    // Register map (byte addresses, one aligned word each)
    // ------------------------------------------------------------------
    localparam int MT_ADR_W = 5;
    localparam logic [MT_ADR_W-1:0] MT_OFF_SC = 5'h00;
    localparam logic [MT_ADR_W-1:0] MT_OFF_CLK = 5'h04;
    localparam logic [MT_ADR_W-1:0] MT_OFF_CNT = 5'h08;
    localparam logic [MT_ADR_W-1:0] MT_OFF_MOD = 5'h0C;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int MT_SC_TOF_BIT = 7;
    localparam int MT_SC_IE_BIT = 6;
    localparam int MT_SC_TRST_BIT = 5;
    localparam int MT_SC_STP_BIT = 4;
    localparam int MT_CLK_CSEL_LSB = 4;
    localparam int MT_CLK_PS_LSB = 0;
    localparam int MT_WB_BYTE0 = 0;

    // ------------------------------------------------------------------
    // Widths and values
    // ------------------------------------------------------------------
    localparam int MT_CNT_W = 8;
    localparam int MT_PS_W = 4;
    localparam logic [MT_PS_W-1:0] MT_PS_MAX = 4'h8;
    localparam logic [MT_CNT_W-1:0] MT_CNT_ZERO = 8'h00;
    localparam logic [MT_CNT_W-1:0] MT_CNT_FULL = 8'hFF;
    localparam logic [MT_CNT_W-1:0] MT_CNT_ONE = 8'h01;
    localparam logic [31:0] MT_DAT_ZERO = 32'h0000_0000;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic MT_RST_STP = 1'b1;
    localparam logic MT_RST_IE = 1'b0;
    localparam logic MT_RST_TOF = 1'b0;
    localparam logic [MT_PS_W-1:0] MT_RST_PS = 4'h0;
    localparam logic [MT_CNT_W-1:0] MT_RST_MOD = 8'h00;

    // Prescaler input source select
    typedef enum logic [1:0] {
        MT_SRC_BUS = 2'b00,
        MT_SRC_FIX = 2'b01,
        MT_SRC_EXT_FALL = 2'b10,
        MT_SRC_EXT_RISE = 2'b11
    } mt_src_e;

    // Wishbone request and answer
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [MT_ADR_W-1:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } mt_wb_req_s;

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } mt_wb_rsp_s;

endpackage

// file: rtl/mt_edge_sync.sv
// Two-flop synchroniser with edge detection for a level from outside
// the bus clock domain.
// Assumes the input toggles no faster than a quarter of clk_i.
`timescale 1ns/1ps
module mt_edge_sync (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Asynchronous level in
    input wire logic async_i,
    // Edge pulses, one cycle each
    output logic rise_o,
    output logic fall_o
);
    import mt_pkg::*;

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
    } mt_sync_s;

    mt_sync_s st_reg;
    mt_sync_s st_next;

    // Only s2 reads s1; edges look at s2 and s3 alone
    always_comb begin
        st_next = st_reg;
        st_next.s1 = async_i;
        st_next.s2 = st_reg.s1;
        st_next.s3 = st_reg.s2;
        if (rst_i) begin
            st_next = '0;
        end
    end

    always_ff @(posedge clk_i) begin
        st_reg <= st_next;
    end

    // Edges; a pin faster than clk/4 would merge pulses here
    assign rise_o = st_reg.s2 & ~st_reg.s3; // R9 R10
    assign fall_o = ~st_reg.s2 & st_reg.s3; // R9

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    chk_edge_single: assert property ((rise_o | fall_o) // R9
        |=> !(rise_o | fall_o))
        else $error("edge pulse longer than one cycle");

endmodule // mt_edge_sync

// file: rtl/mt_prescaler.sv
// Power-of-two prescaler: passes one tick in 2**n of the source ticks.
// Assumes tick_i is already gated by the counter's run condition.
`timescale 1ns/1ps
module mt_prescaler (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Control
    input wire logic [mt_pkg::MT_PS_W-1:0] ps_i,
    input wire logic clr_i,
    // Ticks
    input wire logic tick_i,
    output logic tick_o
);
    import mt_pkg::*;

    typedef struct packed {
        logic [MT_CNT_W-1:0] div;
    } mt_ps_s;

    mt_ps_s st_reg;
    mt_ps_s st_next;
    logic [MT_PS_W-1:0] n_eff;
    logic [MT_CNT_W-1:0] mask;

    // Codes above eight all divide by the largest step
    assign n_eff = (ps_i > MT_PS_MAX) ? MT_PS_MAX : ps_i; // R20

    // Low n bits of the divider must all be ones to pass a tick
    for (genvar g = 0; g < MT_CNT_W; g++) begin : g_mask
        assign mask[g] = (n_eff > MT_PS_W'(g)); // R4
    end

    assign tick_o = tick_i & ((st_reg.div & mask) == mask); // R4

    // Divider advances only on source ticks
    always_comb begin
        st_next = st_reg;
        if (clr_i) begin
            st_next.div = MT_CNT_ZERO;
        end else if (tick_i) begin
            st_next.div = st_reg.div + MT_CNT_ONE;
        end
        if (rst_i) begin
            st_next = '0;
        end
    end

    always_ff @(posedge clk_i) begin
        st_reg <= st_next;
    end

endmodule // mt_prescaler

// file: verif/mt_clk_src_model.sv
// Behavioural clock source for the timer's external and reference pins.
// Assumes clk_i is the bus clock; HALF bus cycles per pin level.
`timescale 1ns/1ps
module mt_clk_src_model #(
    parameter int HALF = 3
) (
    // Bus clock
    input wire logic clk_i,
    // Burst control and pin
    input wire logic run_i,
    output logic pin_o
);
    // Idle low between bursts, like a source that is switched off
    int unsigned cnt = 0;
    logic pin_q = 1'b0;

    assign pin_o = pin_q;

    // A started period always finishes low, so edge counts stay exact;
    // HALF of two or more keeps the pin at or below a quarter of the bus rate
    always @(posedge clk_i) begin
        if (run_i || pin_q) begin
            if (cnt == HALF - 1) begin
                cnt <= 0;
                pin_q <= ~pin_q;
            end else begin
                cnt <= cnt + 1;
            end
        end else begin
            cnt <= 0;
        end
    end
endmodule // mt_clk_src_model

// file: verif/tb.sv
// Self-checking bench for the modulo timer over classic Wishbone.
// Assumes mt_timer_top acks each access; pins come from clock models.
`timescale 1ns/1ps
module tb;
    import mt_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    mt_wb_req_s wb_req = '0;
    mt_wb_rsp_s wb_rsp;
    logic pin_run = 1'b0;
    logic ref_run = 1'b0;
    logic stop_mode = 1'b0;
    logic dbg = 1'b0;
    logic pin, ref_clk, irq;
    logic [7:0] rd, rd0;
    int fails = 0;
    int n_checks = 0;

    // 10 MHz bus clock
    always #50 clk_i = ~clk_i;

    mt_timer_top mt_timer_top_inst (.clk_i(clk_i), .rst_i(rst_i),
        .wb_req_i(wb_req), .wb_rsp_o(wb_rsp),
        .ext_timer_clock_pin_i(pin), .internal_fixed_ref_clock_i(ref_clk),
        .stop_mode_i(stop_mode), .debug_active_i(dbg), .irq_o(irq));
    mt_clk_src_model #(.HALF(3)) pin_src_inst (.clk_i(clk_i),
        .run_i(pin_run), .pin_o(pin));
    mt_clk_src_model #(.HALF(3)) ref_src_inst (.clk_i(clk_i),
        .run_i(ref_run), .pin_o(ref_clk));

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [7:0] exp,
                       input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    // One classic cycle; request held until ack is sampled high
    task automatic wb_xfer(input logic we, input logic [MT_ADR_W-1:0] adr,
                           input logic [7:0] wd, output logic [7:0] rdat);
        int i;
        @(posedge clk_i);
        wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'h1,
                    dat: {24'h00_0000, wd}};
        for (i = 0; i < 20; i++) begin
            @(posedge clk_i);
            if (wb_rsp.ack === 1'b1) begin
                break;
            end
        end
        rdat = wb_rsp.dat[7:0];
        chk("dat_upper", 8'h00, 8'(wb_rsp.dat[31:8] != 24'h00_0000));
        wb_req <= '0;
        if (i == 20) begin
            chk("ack_timeout", 8'h01, 8'h00);
            wrap_up();
        end
    endtask

    task automatic wr(input logic [MT_ADR_W-1:0] adr, input logic [7:0] d);
        logic [7:0] dummy;
        wb_xfer(1'b1, adr, d, dummy);
    endtask

    task automatic rdchk(input string name, input logic [MT_ADR_W-1:0] adr,
                         input logic [7:0] exp);
        logic [7:0] got;
        wb_xfer(1'b0, adr, 8'h00, got);
        chk(name, exp, got);
    endtask

    task automatic do_reset();
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
    endtask

    // Let the counter run for exactly n cycles, frozen before and after
    task automatic gate(input int n);
        stop_mode <= 1'b0;
        repeat (n) @(posedge clk_i);
        stop_mode <= 1'b1;
    endtask

    // Bounded wait for the interrupt request
    task automatic wait_irq();
        int i;
        for (i = 0; i < 100 && irq !== 1'b1; i++) begin
            @(posedge clk_i);
        end
        chk("irq_high", 8'h01, {7'h00, irq});
        if (irq !== 1'b1) begin
            wrap_up();
        end
    endtask

    task automatic check_rst();
        rdchk("sc_rst", MT_OFF_SC, 8'h10);
        rdchk("clk_rst", MT_OFF_CLK, 8'h00);
        rdchk("cnt_rst", MT_OFF_CNT, 8'h00);
        rdchk("mod_rst", MT_OFF_MOD, 8'h00);
        chk("irq_rst", 8'h00, {7'h00, irq});
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        do_reset();
        check_rst();
        wr(MT_OFF_CNT, 8'h55);
        rdchk("cnt_ro", MT_OFF_CNT, 8'h00);
        wr(MT_OFF_MOD, 8'hA5);
        rdchk("mod_rw", MT_OFF_MOD, 8'hA5);
        wr(5'h10, 8'hFF);
        rdchk("unmapped", 5'h10, 8'h00);
        $display("test reset_values done");

        // Modulo 3 on the bus clock; stop mode freezes it
        wr(MT_OFF_MOD, 8'h03);
        wr(MT_OFF_SC, 8'h00);
        repeat (10) @(posedge clk_i);
        stop_mode <= 1'b1;
        wb_xfer(1'b0, MT_OFF_CNT, 8'h00, rd0);
        chk("cnt_le_mod", 8'h01, 8'(rd0 <= 8'h03));
        repeat (20) @(posedge clk_i);
        rdchk("cnt_frozen", MT_OFF_CNT, rd0);
        wr(MT_OFF_SC, 8'h00);
        rdchk("flag_kept", MT_OFF_SC, 8'h80);
        wr(MT_OFF_SC, 8'h00);
        rdchk("flag_clr", MT_OFF_SC, 8'h00);
        $display("test overflow_clear done");

        // Debug freezes the count; a counter reset still acts
        stop_mode <= 1'b0;
        dbg <= 1'b1;
        wb_xfer(1'b0, MT_OFF_CNT, 8'h00, rd0);
        repeat (20) @(posedge clk_i);
        rdchk("dbg_frozen", MT_OFF_CNT, rd0);
        wr(MT_OFF_SC, 8'h20);
        rdchk("dbg_trst", MT_OFF_CNT, 8'h00);
        dbg <= 1'b0;
        repeat (10) @(posedge clk_i);
        rdchk("flag_arm", MT_OFF_SC, 8'h80);
        repeat (10) @(posedge clk_i);
        wr(MT_OFF_SC, 8'h00);
        rdchk("flag_race", MT_OFF_SC, 8'h80);
        $display("test debug_race done");

        // Interrupt: clear the flag first, then enable
        stop_mode <= 1'b1;
        rdchk("flag_pre", MT_OFF_SC, 8'h80);
        wr(MT_OFF_SC, 8'h00);
        wr(MT_OFF_SC, 8'h40);
        chk("irq_quiet", 8'h00, {7'h00, irq});
        stop_mode <= 1'b0;
        wait_irq();
        stop_mode <= 1'b1;
        rdchk("sc_irq", MT_OFF_SC, 8'hC0);
        wr(MT_OFF_SC, 8'h60);
        rdchk("sc_trst", MT_OFF_SC, 8'h40);
        rdchk("cnt_trst", MT_OFF_CNT, 8'h00);
        chk("irq_trst", 8'h00, {7'h00, irq});
        stop_mode <= 1'b0;
        wait_irq();
        stop_mode <= 1'b1;
        wr(MT_OFF_MOD, 8'h03);
        rdchk("sc_modw", MT_OFF_SC, 8'h40);
        rdchk("cnt_modw", MT_OFF_CNT, 8'h00);
        chk("irq_modw", 8'h00, {7'h00, irq});
        $display("test interrupt done");

        // Every prescale code over three and a half divided periods
        wr(MT_OFF_SC, 8'h00);
        wr(MT_OFF_MOD, 8'h00);
        for (int k = 0; k < 16; k++) begin
            int d;
            d = (k > 8) ? 8 : k;
            wr(MT_OFF_CLK, 8'(k));
            wr(MT_OFF_SC, 8'h20);
            gate((7 << d) / 2);
            wb_xfer(1'b0, MT_OFF_CNT, 8'h00, rd);
            chk("ps_count", 8'h01, 8'(rd == 8'h03 || rd == 8'h04));
        end
        $display("test prescale done");

        // Fixed, pin falling and pin rising sources, six pin periods
        stop_mode <= 1'b0;
        for (int s = 1; s < 4; s++) begin
            wr(MT_OFF_CLK, {2'b00, 2'(s), 4'h0});
            wr(MT_OFF_SC, 8'h20);
            if (s == 1) begin
                ref_run <= 1'b1;
            end else begin
                pin_run <= 1'b1;
            end
            repeat (36) @(posedge clk_i);
            ref_run <= 1'b0;
            pin_run <= 1'b0;
            repeat (20) @(posedge clk_i);
            wb_xfer(1'b0, MT_OFF_CNT, 8'h00, rd);
            chk("src_count", (s == 1) ? 8'h03 : 8'h06, rd);
        end
        $display("test sources done");

        // Stop bit freezes, clearing it resumes
        wr(MT_OFF_CLK, 8'h00);
        wr(MT_OFF_SC, 8'h10);
        wb_xfer(1'b0, MT_OFF_CNT, 8'h00, rd0);
        repeat (20) @(posedge clk_i);
        rdchk("stp_frozen", MT_OFF_CNT, rd0);
        wr(MT_OFF_SC, 8'h00);
        wb_xfer(1'b0, MT_OFF_CNT, 8'h00, rd);
        chk("stp_resume", 8'h01, 8'(rd != rd0));
        $display("test stop_bit done");

        // Reset in mid-run restores every default
        do_reset();
        check_rst();
        $display("test second_reset done");
        wrap_up();
    end
endmodule // tb
